// ---- rtl/bcrt_pkg.sv ----
// Constants for the BCD calendar clock and its timer chain
package bcrt_pkg;

  // ---------------------------------------------------------------------------
  // Prescaler chain
  // ---------------------------------------------------------------------------
  localparam logic [1:0] BCRT_SUB_DIV_LAST   = 2'h3;   // Sub-clock edges per count-source tick, minus one
  localparam logic       BCRT_DIV2_LAST      = 1'h1;
  localparam logic [3:0] BCRT_NIB_LAST       = 4'hf;
  localparam logic [7:0] BCRT_BYTE_LAST      = 8'hff;

  // ---------------------------------------------------------------------------
  // Calendar limits (BCD)
  // ---------------------------------------------------------------------------
  localparam logic [6:0] BCRT_SEC_LAST       = 7'h59;
  localparam logic [6:0] BCRT_MIN_LAST       = 7'h59;
  localparam logic [5:0] BCRT_HR24_LAST      = 6'h23;
  localparam logic [5:0] BCRT_HR12_LAST      = 6'h11;
  localparam logic [2:0] BCRT_WDAY_LAST      = 3'h6;
  localparam logic [2:0] BCRT_WDAY_SUNDAY    = 3'h0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [6:0] BCRT_SEC_RST        = 7'h00;
  localparam logic [6:0] BCRT_MIN_RST        = 7'h00;
  localparam logic [5:0] BCRT_HR_RST         = 6'h00;
  localparam logic [2:0] BCRT_WDAY_RST       = 3'h0;

  // ---------------------------------------------------------------------------
  // Modes and pin functions
  // ---------------------------------------------------------------------------
  localparam logic       BCRT_MODE_CALENDAR  = 1'h0;
  localparam logic       BCRT_MODE_COMPARE   = 1'h1;
  localparam logic [1:0] BCRT_PIN_GPIO       = 2'h0;
  localparam logic [1:0] BCRT_PIN_HALF       = 2'h1;
  localparam logic [1:0] BCRT_PIN_QUARTER    = 2'h2;
  localparam logic [1:0] BCRT_PIN_EIGHTH     = 2'h3;

endpackage : bcrt_pkg

// ---- rtl/bcrt_rtc.sv ----
// BCD calendar clock with prescaler chain, compare mode and clock-out pin
`timescale 1ns/1ns

//Function
//- 4-bit and 8-bit counters, two modes
//- 1 s tick via div2, nibble, byte
//- Tick counts seconds, minutes, hours, weekday
//- Run request 1 starts counting
//- Run request 0 halts, counts kept
//- Only one interrupt source selected
//- Interrupt on each seconds update
//- Interrupt on each minutes update
//- Interrupt on each hours update
//- Interrupt on each weekday update
//- Weekly interrupt when weekday becomes Sunday
//- Live BCD counts readable
//- Selectable 12 or 24 hour format
//- Pin is GPIO or sysclk div 2/4/8
//- Status follows request within two ticks
module bcrt_rtc (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       subclk_i,
  input  wire logic       mode_compare_i,
  input  wire logic       compare_use_nibble_i,
  input  wire logic       run_request_bit_i,
  input  wire logic       hour_24_i,
  input  wire logic       weekly_irq_enable_i,
  input  wire logic       daily_irq_enable_i,
  input  wire logic       hourly_irq_enable_i,
  input  wire logic       minutely_irq_enable_i,
  input  wire logic       secondly_irq_enable_i,
  input  wire logic       sec_wr_i,
  input  wire logic [6:0] sec_wdata_i,
  input  wire logic       min_wr_i,
  input  wire logic [6:0] min_wdata_i,
  input  wire logic       hr_wr_i,
  input  wire logic [5:0] hr_wdata_i,
  input  wire logic       pm_wdata_i,
  input  wire logic       wday_wr_i,
  input  wire logic [2:0] wday_wdata_i,
  input  wire logic [1:0] pin_sel_i,
  input  wire logic       pin_gpio_i,
  output logic            running_status_flag_o,
  output logic [6:0]      seconds_count_reg_o,
  output logic [6:0]      minutes_count_reg_o,
  output logic [5:0]      hours_count_reg_o,
  output logic            pm_flag_o,
  output logic [2:0]      weekday_count_reg_o,
  output logic [7:0]      byte_count_o,
  output logic            irq_o,
  output logic            timer_output_pin_o
);
  import bcrt_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic       sub_meta_reg, sub_sync_reg, sub_prev_reg;
  logic [1:0] sub_cnt_reg, sub_cnt_next;
  logic       run_reg, run_next;
  logic       div2_reg, div2_next;
  logic [3:0] nib_reg, nib_next;
  logic [7:0] byte_reg, byte_next;
  logic [6:0] sec_reg, sec_next;
  logic [6:0] min_reg, min_next;
  logic [5:0] hr_reg, hr_next;
  logic       pm_reg, pm_next;
  logic [2:0] wday_reg, wday_next;
  logic       irq_reg, irq_next;
  logic [2:0] sys_div_reg, sys_div_next;
  logic       pin_reg, pin_next;

  // BCD increment of a two-digit value
  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    logic [6:0] r;
    r = 7'h00;
    if (v[3:0] == 4'h9) begin
      r = {3'(v[6:4] + 3'h1), 4'h0};
    end else begin
      r = {v[6:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction : bcd_inc

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  logic       sub_rise;
  logic       cs_tick;
  logic       step;
  logic       sec_tick, min_tick, hr_tick, day_tick, week_tick;
  logic       cmp_match;
  logic       wr_ok;
  logic [5:0] hr_last;

  always_comb begin
    sub_rise     = sub_sync_reg & ~sub_prev_reg;
    sub_cnt_next = sub_cnt_reg;
    cs_tick      = 1'b0;
    if (sub_rise) begin
      sub_cnt_next = 2'(sub_cnt_reg + 2'h1);
      cs_tick      = (sub_cnt_reg == BCRT_SUB_DIV_LAST);
    end

    // Status catches up on the next count-source tick, well inside two
    run_next = cs_tick ? run_request_bit_i : run_reg;
    step     = cs_tick & run_reg & run_request_bit_i;

    div2_next = div2_reg;
    nib_next  = nib_reg;
    byte_next = byte_reg;
    sec_tick  = 1'b0;
    cmp_match = 1'b0;

    if (step) begin
      div2_next = ~div2_reg;
      if (mode_compare_i == BCRT_MODE_CALENDAR) begin
        if (div2_reg == BCRT_DIV2_LAST) begin
          nib_next = 4'(nib_reg + 4'h1);
          if (nib_reg == BCRT_NIB_LAST) begin
            byte_next = 8'(byte_reg + 8'h01);
            sec_tick  = (byte_reg == BCRT_BYTE_LAST);
          end
        end
      end else begin
        // Compare mode: byte counter matched against the minutes value
        if ((div2_reg == BCRT_DIV2_LAST) &&
            (~compare_use_nibble_i || (nib_reg == BCRT_NIB_LAST))) begin
          if (compare_use_nibble_i) begin
            nib_next = 4'(nib_reg + 4'h1);
          end
          if (byte_reg == {1'b0, min_reg}) begin
            byte_next = 8'h00;
            cmp_match = 1'b1;
          end else begin
            byte_next = 8'(byte_reg + 8'h01);
          end
        end else if (compare_use_nibble_i && (div2_reg == BCRT_DIV2_LAST)) begin
          nib_next = 4'(nib_reg + 4'h1);
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Calendar counters
  // ---------------------------------------------------------------------------
  always_comb begin
    // Stopped means both request and status low; otherwise writes dropped
    wr_ok     = ~run_request_bit_i & ~run_reg;
    sec_next  = sec_reg;
    min_next  = min_reg;
    hr_next   = hr_reg;
    pm_next   = pm_reg;
    wday_next = wday_reg;
    min_tick  = 1'b0;
    hr_tick   = 1'b0;
    day_tick  = 1'b0;
    week_tick = 1'b0;
    hr_last   = hour_24_i ? BCRT_HR24_LAST : BCRT_HR12_LAST;

    if (sec_tick) begin
      if (sec_reg == BCRT_SEC_LAST) begin
        sec_next = BCRT_SEC_RST;
        min_tick = 1'b1;
      end else begin
        sec_next = bcd_inc(sec_reg);
      end
    end
    if (min_tick) begin
      if (min_reg == BCRT_MIN_LAST) begin
        min_next = BCRT_MIN_RST;
        hr_tick  = 1'b1;
      end else begin
        min_next = bcd_inc(min_reg);
      end
    end
    if (hr_tick) begin
      if (hr_reg == hr_last) begin
        hr_next = BCRT_HR_RST;
        // Day turns at midnight: in 12-hour form that is PM to AM
        pm_next  = hour_24_i ? 1'b0 : ~pm_reg;
        day_tick = hour_24_i | pm_reg;
      end else begin
        hr_next = 6'(bcd_inc({1'b0, hr_reg}));
      end
    end
    if (day_tick) begin
      wday_next = (wday_reg == BCRT_WDAY_LAST) ? BCRT_WDAY_SUNDAY : 3'(wday_reg + 3'h1);
      week_tick = (wday_reg == BCRT_WDAY_LAST);
    end

    // Values are taken as given; BCD form is up to software
    if (wr_ok) begin
      if (sec_wr_i) begin
        sec_next = sec_wdata_i;
      end
      if (min_wr_i) begin
        min_next = min_wdata_i;
      end
      if (hr_wr_i) begin
        hr_next = hr_wdata_i;
        pm_next = pm_wdata_i & ~hour_24_i;
      end
      if (wday_wr_i) begin
        wday_next = wday_wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt select
  // ---------------------------------------------------------------------------
  always_comb begin
    // One source by priority, so overlapping enables still give one timing
    if (mode_compare_i == BCRT_MODE_COMPARE) begin
      irq_next = cmp_match;
    end else if (weekly_irq_enable_i) begin
      irq_next = week_tick;
    end else if (daily_irq_enable_i) begin
      irq_next = day_tick;
    end else if (hourly_irq_enable_i) begin
      irq_next = hr_tick;
    end else if (minutely_irq_enable_i) begin
      irq_next = min_tick;
    end else if (secondly_irq_enable_i) begin
      irq_next = sec_tick;
    end else begin
      irq_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Clock-out pin
  // ---------------------------------------------------------------------------
  always_comb begin
    sys_div_next = 3'(sys_div_reg + 3'h1);
    unique case (pin_sel_i)
      BCRT_PIN_GPIO:    pin_next = pin_gpio_i;
      BCRT_PIN_HALF:    pin_next = sys_div_next[0];
      BCRT_PIN_QUARTER: pin_next = sys_div_next[1];
      BCRT_PIN_EIGHTH:  pin_next = sys_div_next[2];
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sub_meta_reg <= 1'b0;
      sub_sync_reg <= 1'b0;
      sub_prev_reg <= 1'b0;
      sub_cnt_reg  <= 2'h0;
      run_reg      <= 1'b0;
      div2_reg     <= 1'b0;
      nib_reg      <= 4'h0;
      byte_reg     <= 8'h00;
      sec_reg      <= BCRT_SEC_RST;
      min_reg      <= BCRT_MIN_RST;
      hr_reg       <= BCRT_HR_RST;
      pm_reg       <= 1'b0;
      wday_reg     <= BCRT_WDAY_RST;
      irq_reg      <= 1'b0;
      sys_div_reg  <= 3'h0;
      pin_reg      <= 1'b0;
    end else begin
      sub_meta_reg <= subclk_i;
      sub_sync_reg <= sub_meta_reg;
      sub_prev_reg <= sub_sync_reg;
      sub_cnt_reg  <= sub_cnt_next;
      run_reg      <= run_next;
      div2_reg     <= div2_next;
      nib_reg      <= nib_next;
      byte_reg     <= byte_next;
      sec_reg      <= sec_next;
      min_reg      <= min_next;
      hr_reg       <= hr_next;
      pm_reg       <= pm_next;
      wday_reg     <= wday_next;
      irq_reg      <= irq_next;
      sys_div_reg  <= sys_div_next;
      pin_reg      <= pin_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign running_status_flag_o = run_reg;
  assign seconds_count_reg_o   = sec_reg;
  assign minutes_count_reg_o   = min_reg;
  assign hours_count_reg_o     = hr_reg;
  assign pm_flag_o             = pm_reg;
  assign weekday_count_reg_o   = wday_reg;
  assign byte_count_o          = byte_reg;
  assign irq_o                 = irq_reg;
  assign timer_output_pin_o    = pin_reg;

endmodule : bcrt_rtc

// ---- sim/bcrt_rtc_assertions.sv ----
// Port-level checks of the calendar clock
`timescale 1ns/1ns
module bcrt_rtc_chk (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       mode_compare_i,
  input wire logic       run_request_bit_i,
  input wire logic       sec_wr_i,
  input wire logic [6:0] sec_wdata_i,
  input wire logic       wday_wr_i,
  input wire logic [2:0] wday_wdata_i,
  input wire logic [1:0] pin_sel_i,
  input wire logic       pin_gpio_i,
  input wire logic       running_status_flag_o,
  input wire logic [6:0] seconds_count_reg_o,
  input wire logic [2:0] weekday_count_reg_o,
  input wire logic [7:0] byte_count_o,
  input wire logic       irq_o,
  input wire logic       timer_output_pin_o
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Bound of 60 covers sub-clock periods up to 14 core cycles
  AST_STATUS_RISE: assert property ($rose(run_request_bit_i) |-> ##[0:60] (running_status_flag_o || !run_request_bit_i))
    else $error("status did not follow run request");
  AST_STATUS_FALL: assert property ($fell(run_request_bit_i) |-> ##[0:60] (!running_status_flag_o || run_request_bit_i))
    else $error("status did not follow stop request");
  AST_STATUS_CAUSE: assert property ($rose(running_status_flag_o) |-> $past(run_request_bit_i))
    else $error("status rose without request");
  AST_HALT_HOLD: assert property (!running_status_flag_o |=> $stable(byte_count_o))
    else $error("counter moved while halted");
  AST_BYTE_STEP: assert property ($changed(byte_count_o) |-> byte_count_o == $past(byte_count_o) + 8'h01 || byte_count_o == 8'h00)
    else $error("byte counter jumped");
  AST_SEC_WRITE: assert property (sec_wr_i && !mode_compare_i && !run_request_bit_i && !running_status_flag_o |=> seconds_count_reg_o == $past(sec_wdata_i))
    else $error("seconds write lost");
  AST_WDAY_WRITE: assert property (wday_wr_i && !run_request_bit_i && !running_status_flag_o |=> weekday_count_reg_o == $past(wday_wdata_i))
    else $error("weekday write lost");
  AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  AST_CMP_CLEAR: assert property (irq_o && mode_compare_i && $past(mode_compare_i) |-> byte_count_o == 8'h00)
    else $error("compare interrupt without counter clear");
  AST_PIN_GPIO: assert property ((pin_sel_i == 2'h0) [*2] |-> timer_output_pin_o == $past(pin_gpio_i))
    else $error("pin does not follow port level");
  AST_PIN_HALF: assert property ((pin_sel_i == 2'h1) [*3] |-> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("pin does not toggle at half rate");
endmodule : bcrt_rtc_chk

bind bcrt_rtc bcrt_rtc_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mode_compare_i(mode_compare_i),
  .run_request_bit_i(run_request_bit_i), .sec_wr_i(sec_wr_i), .sec_wdata_i(sec_wdata_i), .wday_wr_i(wday_wr_i),
  .wday_wdata_i(wday_wdata_i), .pin_sel_i(pin_sel_i), .pin_gpio_i(pin_gpio_i),
  .running_status_flag_o(running_status_flag_o), .seconds_count_reg_o(seconds_count_reg_o),
  .weekday_count_reg_o(weekday_count_reg_o), .byte_count_o(byte_count_o), .irq_o(irq_o),
  .timer_output_pin_o(timer_output_pin_o));

// ---- sim/test_bcrt_rtc.sv ----
// Self-checking bench for the calendar clock
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_bcrt_rtc;
  import bcrt_pkg::*;
  logic       core_clk_i = 0, rst_n_i = 0, subclk_i = 0, mode = 0, nib = 0, run = 0, h24 = 1;
  logic       sw = 0, mw = 0, hw = 0, ww = 0, pd = 0, gpio = 0, stat, pm, irq, pin, lp;
  logic [4:0] ien = 0;
  logic [6:0] sd = 0, md = 0, sec, mnt, s, m;
  logic [5:0] hd = 0, hrs, h;
  logic [2:0] wd = 0, wk, w;
  logic [1:0] psel = 0;
  logic [7:0] bc, v;
  int         seed, n_mismatch, comparisons, i, k, cnt, sdiv;
  // Core cycles per count-source tick: four sub-clock periods of 6
  localparam int CS_CYC = 24;
  bcrt_rtc DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .subclk_i(subclk_i), .mode_compare_i(mode),
    .compare_use_nibble_i(nib), .run_request_bit_i(run), .hour_24_i(h24), .weekly_irq_enable_i(ien[4]),
    .daily_irq_enable_i(ien[3]), .hourly_irq_enable_i(ien[2]), .minutely_irq_enable_i(ien[1]),
    .secondly_irq_enable_i(ien[0]), .sec_wr_i(sw), .sec_wdata_i(sd), .min_wr_i(mw), .min_wdata_i(md),
    .hr_wr_i(hw), .hr_wdata_i(hd), .pm_wdata_i(pd), .wday_wr_i(ww), .wday_wdata_i(wd), .pin_sel_i(psel),
    .pin_gpio_i(gpio), .running_status_flag_o(stat), .seconds_count_reg_o(sec), .minutes_count_reg_o(mnt),
    .hours_count_reg_o(hrs), .pm_flag_o(pm), .weekday_count_reg_o(wk), .byte_count_o(bc), .irq_o(irq),
    .timer_output_pin_o(pin));
  // ---------------------------------------------------------------------------
  // Clocks and helpers
  // ---------------------------------------------------------------------------
  initial forever #10 core_clk_i = ~core_clk_i;
  // Sub-clock half period of 3 core cycles, a period of 6, well under the 14 the checks cover
  always @(negedge core_clk_i) begin
    sdiv = (sdiv == 2) ? 0 : sdiv + 1;
    if (sdiv == 0) subclk_i = ~subclk_i;
  end
  function automatic logic [6:0] bcd(input int n);
    return 7'((n / 10) * 16 + n % 10);
  endfunction : bcd
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick
  task automatic wait_stat(input logic e);
    for (int j = 0; j < 2 * CS_CYC + 4 && stat !== e; j++) tick(1);
    `CHK("status", e, stat)
  endtask : wait_stat
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask : wait_irq
  task automatic wr(input logic [6:0] a, b, input logic [5:0] c, input logic p, input logic [2:0] d);
    tick(1);
    {sw, mw, hw, ww} = 4'hf; sd = a; md = b; hd = c; pd = p; wd = d;
    tick(1);
    {sw, mw, hw, ww} = 4'h0;
    tick(1);
  endtask : wr
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #(20 * 20000);
    n_mismatch++;
    end_of_test();
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'hdb0e;
    tick(3);
    rst_n_i = 1;
    tick(1);
    `CHK("seconds", 7'h00, sec)
    for (i = 0; i < 8; i++) begin
      h24 = i[0];
      s = bcd($unsigned($random(seed)) % 60);
      m = bcd(i == 0 ? 59 : $unsigned($random(seed)) % 60);
      h = 6'(bcd($unsigned($random(seed)) % (h24 ? 24 : 12)));
      w = 3'($unsigned($random(seed)) % 7);
      wr(s, m, h, i[1], w);
      `CHK("seconds", s, sec)
      `CHK("minutes", m, mnt)
      `CHK("hours", h, hrs)
      `CHK("pm", i[1] & ~h24, pm)
      `CHK("weekday", w, wk)
    end
    ien = 5'($random(seed));
    run = 1;
    wait_stat(1'b1);
    wr(bcd(1), bcd(2), 6'h03, 1'b0, 3'h4);
    `CHK("refused write", s, sec)
    tick(1600);
    `CHK("counter moving", 1'b1, bc !== 8'h00)
    run = 0;
    wait_stat(1'b0);
    v = bc;
    tick(300);
    `CHK("held counter", v, bc)
    `CHK("held seconds", s, sec)
    mode = 1;
    wr(s, 7'h02, 6'h00, 1'b0, 3'h0);
    for (k = 0; k < 2; k++) begin
      nib = k[0];
      run = 1;
      wait_irq(2600, cnt);
      `CHK("compare interrupt", 1'b1, irq)
      wait_irq(2600, cnt);
      `CHK("compare period", (k == 0 ? 2 : 32) * 3 * CS_CYC, cnt)
      run = 0;
      wait_stat(1'b0);
    end
    mode = 0;
    for (k = 0; k < 4; k++) begin
      psel = 2'(k);
      gpio = 1'($random(seed));
      tick(4);
      cnt = 0;
      lp = pin;
      repeat (16) begin
        tick(1);
        cnt += (pin !== lp);
        lp = pin;
      end
      `CHK("pin toggles", (k == 0) ? 0 : 16 >> (k - 1), cnt)
      if (k == 0) `CHK("pin level", gpio, pin)
    end
    end_of_test();
  end
endmodule : test_bcrt_rtc
